// ==== core/asp_param_bank.sv ====
// Parameter bank for analog input scaling, curve shaping and calculated frequency.
// Assumes the serial framing layer presents one-cycle read and write strobes
// with a register number and a 16-bit word, all on clk_in.
`timescale 1ns/1ps

module asp_param_bank (
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic               wr_en_in,
	input  wire logic               rd_en_in,
	input  wire logic [15:0]        addr_in,
	input  wire logic [15:0]        wr_data_in,
	output logic [15:0]             rd_data_out,
	output logic                    rd_valid_out,
	output logic                    wr_err_out,
	output logic [31:0]             cur_start_freq_out,
	output logic [31:0]             cur_end_freq_out,
	output logic [6:0]              cur_start_ratio_out,
	output logic [6:0]              cur_end_ratio_out,
	output logic [31:0]             cur_low_freq_out,
	output logic signed [31:0]      aux_start_freq_out,
	output logic signed [31:0]      aux_end_freq_out,
	output logic signed [7:0]       aux_start_ratio_out,
	output logic signed [7:0]       aux_end_ratio_out,
	output logic [3:0]              accel_curve_out,
	output logic [3:0]              decel_curve_out,
	output logic [7:0]              src_a_onehot_out,
	output logic [7:0]              src_b_onehot_out,
	output logic [2:0]              op_onehot_out,
	output logic signed [31:0]      freq_add_signed_out,
	output logic [23:0]             els_ratio_out
);
	import asp_pkg::*;

	asp_state_t q;
	asp_state_t d;

	function automatic logic [7:0] src_decode(input logic [2:0] code);
		src_decode = 8'h01 << code;
	endfunction

	function automatic asp_state_t reset_state();
		asp_state_t s;
		s = '0;
		s.cur_er = ASP_RST_CUR_ER;
		s.aux_sr = ASP_RST_AUX_SR;
		s.aux_er = ASP_RST_AUX_ER;
		s.acc_curve = ASP_RST_CURVE;
		s.dec_curve = ASP_RST_CURVE;
		s.els = {4{ASP_RST_ELS}};
		s.src_a_oh = src_decode(3'h0);
		s.src_b_oh = src_decode(3'h0);
		s.op_oh = 3'h1;
		return s;
	endfunction

	// Wide values read back as high word at the lower number.
	function automatic logic [15:0] read_word(input asp_state_t s, input logic [15:0] a);
		logic [15:0] r;
		r = 16'h0000;
		if (a >= ASP_OFS_ELS_FIRST && a <= ASP_OFS_ELS_LAST) begin
			r = {10'h000, s.els[2'(a - ASP_OFS_ELS_FIRST)]};
		end
		case (a)
			ASP_OFS_CUR_SF_HI:  r = s.cur_sf[31:16];
			ASP_OFS_CUR_SF_LO:  r = s.cur_sf[15:0];
			ASP_OFS_CUR_EF_HI:  r = s.cur_ef[31:16];
			ASP_OFS_CUR_EF_LO:  r = s.cur_ef[15:0];
			ASP_OFS_CUR_SR:     r = {9'h000, s.cur_sr};
			ASP_OFS_CUR_ER:     r = {9'h000, s.cur_er};
			ASP_OFS_CUR_SEL:    r = {15'h0000, s.cur_sel};
			ASP_OFS_AUX_SF_HI:  r = s.aux_sf[31:16];
			ASP_OFS_AUX_SF_LO:  r = s.aux_sf[15:0];
			ASP_OFS_AUX_EF_HI:  r = s.aux_ef[31:16];
			ASP_OFS_AUX_EF_LO:  r = s.aux_ef[15:0];
			ASP_OFS_AUX_SR:     r = {{8{s.aux_sr[7]}}, s.aux_sr};
			ASP_OFS_AUX_ER:     r = {{8{s.aux_er[7]}}, s.aux_er};
			ASP_OFS_ACC_CURVE:  r = {12'h000, s.acc_curve};
			ASP_OFS_DEC_CURVE:  r = {12'h000, s.dec_curve};
			ASP_OFS_SRC_A:      r = {13'h0000, s.src_a};
			ASP_OFS_SRC_B:      r = {13'h0000, s.src_b};
			ASP_OFS_OPERATOR:   r = {14'h0000, s.op};
			ASP_OFS_ADD_AMT_HI: r = s.add_amt[31:16];
			ASP_OFS_ADD_AMT_LO: r = s.add_amt[15:0];
			ASP_OFS_ADD_SIGN:   r = {15'h0000, s.add_sgn};
			default: ;
		endcase
		return r;
	endfunction

	// An out-of-range write leaves the setting untouched and pulses the error flag,
	// so a setting can never hold a value the motor-control math cannot use.
	always_comb begin
		logic [31:0] wide;
		logic        bad;
		wide = {q.hold, wr_data_in};
		bad = 1'b0;
		d = q;
		d.rd_valid = 1'b0;
		d.wr_err = 1'b0;
		if (wr_en_in) begin
			if (addr_in >= ASP_OFS_ELS_FIRST && addr_in <= ASP_OFS_ELS_LAST) begin
				if (wr_data_in <= ASP_ELS_MAX) begin
					d.els[2'(addr_in - ASP_OFS_ELS_FIRST)] = wr_data_in[5:0];
				end else begin
					bad = 1'b1;
				end
			end
			case (addr_in)
				ASP_OFS_CUR_SF_HI, ASP_OFS_CUR_EF_HI, ASP_OFS_AUX_SF_HI,
				ASP_OFS_AUX_EF_HI, ASP_OFS_ADD_AMT_HI: begin
					d.hold = wr_data_in;
				end
				ASP_OFS_CUR_SF_LO: begin
					if (wide <= ASP_FREQ_MAX) d.cur_sf = wide;
					else bad = 1'b1;
				end
				ASP_OFS_CUR_EF_LO: begin
					if (wide <= ASP_FREQ_MAX) d.cur_ef = wide;
					else bad = 1'b1;
				end
				ASP_OFS_CUR_SR: begin
					if (wr_data_in <= {9'h000, q.cur_er}) d.cur_sr = wr_data_in[6:0];
					else bad = 1'b1;
				end
				ASP_OFS_CUR_ER: begin
					if (wr_data_in >= {9'h000, q.cur_sr} && wr_data_in <= ASP_RATIO_MAX) begin
						d.cur_er = wr_data_in[6:0];
					end else begin
						bad = 1'b1;
					end
				end
				ASP_OFS_CUR_SEL: begin
					if (wr_data_in <= 16'h0001) d.cur_sel = wr_data_in[0];
					else bad = 1'b1;
				end
				ASP_OFS_AUX_SF_LO: begin
					if ($signed(wide) >= $signed(ASP_FREQ_MIN_S) &&
					    $signed(wide) <= $signed(ASP_FREQ_MAX)) d.aux_sf = wide;
					else bad = 1'b1;
				end
				ASP_OFS_AUX_EF_LO: begin
					if ($signed(wide) >= $signed(ASP_FREQ_MIN_S) &&
					    $signed(wide) <= $signed(ASP_FREQ_MAX)) d.aux_ef = wide;
					else bad = 1'b1;
				end
				ASP_OFS_AUX_SR: begin
					if ($signed(wr_data_in) >= $signed(ASP_AUX_RATIO_MIN) &&
					    $signed(wr_data_in) <= $signed({{8{q.aux_er[7]}}, q.aux_er})) begin
						d.aux_sr = wr_data_in[7:0];
					end else begin
						bad = 1'b1;
					end
				end
				ASP_OFS_AUX_ER: begin
					if ($signed(wr_data_in) >= $signed({{8{q.aux_sr[7]}}, q.aux_sr}) &&
					    $signed(wr_data_in) <= $signed(ASP_RATIO_MAX)) begin
						d.aux_er = wr_data_in[7:0];
					end else begin
						bad = 1'b1;
					end
				end
				ASP_OFS_ACC_CURVE: begin
					if (wr_data_in >= ASP_CURVE_MIN && wr_data_in <= ASP_CURVE_MAX) begin
						d.acc_curve = wr_data_in[3:0];
					end else begin
						bad = 1'b1;
					end
				end
				ASP_OFS_DEC_CURVE: begin
					if (wr_data_in >= ASP_CURVE_MIN && wr_data_in <= ASP_CURVE_MAX) begin
						d.dec_curve = wr_data_in[3:0];
					end else begin
						bad = 1'b1;
					end
				end
				ASP_OFS_SRC_A: begin
					if (wr_data_in <= ASP_SRC_MAX) d.src_a = wr_data_in[2:0];
					else bad = 1'b1;
				end
				ASP_OFS_SRC_B: begin
					if (wr_data_in <= ASP_SRC_MAX) d.src_b = wr_data_in[2:0];
					else bad = 1'b1;
				end
				ASP_OFS_OPERATOR: begin
					if (wr_data_in <= ASP_OP_MAX) d.op = wr_data_in[1:0];
					else bad = 1'b1;
				end
				ASP_OFS_ADD_AMT_LO: begin
					if (wide <= ASP_FREQ_MAX) d.add_amt = wide;
					else bad = 1'b1;
				end
				ASP_OFS_ADD_SIGN: begin
					if (wr_data_in <= 16'h0001) d.add_sgn = wr_data_in[0];
					else bad = 1'b1;
				end
				default: ;
			endcase
			d.wr_err = bad;
		end
		if (rd_en_in) begin
			d.rd_data = read_word(q, addr_in);
			d.rd_valid = 1'b1;
		end
		d.low_freq = d.cur_sel ? 32'h0000_0000 : d.cur_sf;
		d.src_a_oh = src_decode(d.src_a);
		d.src_b_oh = src_decode(d.src_b);
		d.op_oh = 3'(3'h1 << d.op);
		d.add_eff = d.add_sgn ? -$signed(d.add_amt) : $signed(d.add_amt);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			q <= reset_state();
		end else begin
			q <= d;
		end
	end

	assign rd_data_out = q.rd_data;
	assign rd_valid_out = q.rd_valid;
	assign wr_err_out = q.wr_err;
	assign cur_start_freq_out = q.cur_sf;
	assign cur_end_freq_out = q.cur_ef;
	assign cur_start_ratio_out = q.cur_sr;
	assign cur_end_ratio_out = q.cur_er;
	assign cur_low_freq_out = q.low_freq;
	assign aux_start_freq_out = q.aux_sf;
	assign aux_end_freq_out = q.aux_ef;
	assign aux_start_ratio_out = q.aux_sr;
	assign aux_end_ratio_out = q.aux_er;
	assign accel_curve_out = q.acc_curve;
	assign decel_curve_out = q.dec_curve;
	assign src_a_onehot_out = q.src_a_oh;
	assign src_b_onehot_out = q.src_b_oh;
	assign op_onehot_out = q.op_oh;
	assign freq_add_signed_out = q.add_eff;
	assign els_ratio_out = q.els;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence hi_zero_s;
		wr_en_in && addr_in == ASP_OFS_CUR_SF_HI && wr_data_in == 16'h0000;
	endsequence
	sequence lo_legal_s;
		wr_en_in && addr_in == ASP_OFS_CUR_SF_LO && wr_data_in <= 16'h9C40;
	endsequence
	// A write in the gap between the two halves could replace the shared hold word.
	sequence idle_s;
		!wr_en_in;
	endsequence

	cur_ratio_order_a: assert property (cur_start_ratio_out <= cur_end_ratio_out &&
		cur_end_ratio_out <= 7'h64) else $error("current ratios out of order");
	aux_ratio_order_a: assert property (aux_start_ratio_out <= aux_end_ratio_out &&
		aux_start_ratio_out >= -8'sd100 && aux_end_ratio_out <= 8'sd100)
		else $error("aux ratios out of order");
	low_freq_zero_a: assert property (wr_en_in && addr_in == ASP_OFS_CUR_SEL &&
		wr_data_in == 16'h0001 |=> cur_low_freq_out == 32'h0000_0000)
		else $error("start select 01 did not give zero");
	curve_range_a: assert property (accel_curve_out inside {[4'h1:4'hA]} &&
		decel_curve_out inside {[4'h1:4'hA]}) else $error("curve strength out of range");
	src_onehot_a: assert property (wr_en_in && addr_in == ASP_OFS_SRC_A &&
		wr_data_in <= 16'h0007 |=> src_a_onehot_out == (8'h01 << $past(wr_data_in[2:0])))
		else $error("source decode wrong");
	op_onehot_a: assert property ($onehot(op_onehot_out) &&
		op_onehot_out == 3'(3'h1 << q.op)) else $error("operator decode wrong");
	add_sign_a: assert property (wr_en_in && addr_in == ASP_OFS_ADD_SIGN &&
		wr_data_in == 16'h0001 |=> freq_add_signed_out <= 32'sd0)
		else $error("subtract sign gave positive amount");
	add_range_a: assert property (freq_add_signed_out <= 32'sd40000 &&
		freq_add_signed_out >= -32'sd40000) else $error("addition amount out of range");
	els_range_a: assert property (els_ratio_out[5:0] <= 6'h32 &&
		els_ratio_out[11:6] <= 6'h32 && els_ratio_out[17:12] <= 6'h32 &&
		els_ratio_out[23:18] <= 6'h32) else $error("curve ratio out of range");
	word_pair_a: assert property (hi_zero_s ##1 idle_s ##1 lo_legal_s |=>
		cur_start_freq_out == {16'h0000, $past(wr_data_in)})
		else $error("wide setting not assembled");
	unused_read_a: assert property (rd_en_in && addr_in == 16'h1288 |=>
		rd_valid_out && rd_data_out == 16'h0000) else $error("unused address read nonzero");
	src_b_onehot_a: assert property (wr_en_in && addr_in == ASP_OFS_SRC_B &&
		wr_data_in <= 16'h0007 |=> src_b_onehot_out == (8'h01 << $past(wr_data_in[2:0])))
		else $error("source b decode wrong");
	low_freq_start_a: assert property (wr_en_in && addr_in == ASP_OFS_CUR_SEL &&
		wr_data_in == 16'h0000 |=> cur_low_freq_out == cur_start_freq_out)
		else $error("start select 00 did not give start frequency");
	// A refused write must leave the stored setting exactly as it was.
	curve_refuse_a: assert property (wr_en_in && addr_in == ASP_OFS_ACC_CURVE &&
		!(wr_data_in >= ASP_CURVE_MIN && wr_data_in <= ASP_CURVE_MAX) |=>
		wr_err_out && $stable(accel_curve_out)) else $error("bad curve strength taken");
	els_refuse_a: assert property (wr_en_in && addr_in >= ASP_OFS_ELS_FIRST &&
		addr_in <= ASP_OFS_ELS_LAST && wr_data_in > ASP_ELS_MAX |=>
		wr_err_out && $stable(els_ratio_out)) else $error("bad curve ratio taken");
	hi_alone_a: assert property (wr_en_in && addr_in == ASP_OFS_ADD_AMT_HI |=>
		$stable(freq_add_signed_out)) else $error("high word alone changed the amount");
	unused_write_a: assert property (wr_en_in && (addr_in == 16'h1288 ||
		addr_in == 16'h12B2) |=> !wr_err_out) else $error("unused address write flagged");
endmodule

// ==== core/asp_pkg.sv ====
// Package for the analog scaling and calculation parameter bank.
// Assumes a 16-bit register port on one clock with a synchronous reset.
package asp_pkg;
	localparam logic [15:0] ASP_OFS_CUR_SF_HI   = 16'h1281;
	localparam logic [15:0] ASP_OFS_CUR_SF_LO   = 16'h1282;
	localparam logic [15:0] ASP_OFS_CUR_EF_HI   = 16'h1283;
	localparam logic [15:0] ASP_OFS_CUR_EF_LO   = 16'h1284;
	localparam logic [15:0] ASP_OFS_CUR_SR      = 16'h1285;
	localparam logic [15:0] ASP_OFS_CUR_ER      = 16'h1286;
	localparam logic [15:0] ASP_OFS_CUR_SEL     = 16'h1287;
	localparam logic [15:0] ASP_OFS_AUX_SF_HI   = 16'h128D;
	localparam logic [15:0] ASP_OFS_AUX_SF_LO   = 16'h128E;
	localparam logic [15:0] ASP_OFS_AUX_EF_HI   = 16'h128F;
	localparam logic [15:0] ASP_OFS_AUX_EF_LO   = 16'h1290;
	localparam logic [15:0] ASP_OFS_AUX_SR      = 16'h1291;
	localparam logic [15:0] ASP_OFS_AUX_ER      = 16'h1292;
	localparam logic [15:0] ASP_OFS_ACC_CURVE   = 16'h12A5;
	localparam logic [15:0] ASP_OFS_DEC_CURVE   = 16'h12A6;
	localparam logic [15:0] ASP_OFS_SRC_A       = 16'h12AF;
	localparam logic [15:0] ASP_OFS_SRC_B       = 16'h12B0;
	localparam logic [15:0] ASP_OFS_OPERATOR    = 16'h12B1;
	localparam logic [15:0] ASP_OFS_ADD_AMT_HI  = 16'h12B3;
	localparam logic [15:0] ASP_OFS_ADD_AMT_LO  = 16'h12B4;
	localparam logic [15:0] ASP_OFS_ADD_SIGN    = 16'h12B5;
	localparam logic [15:0] ASP_OFS_ELS_FIRST   = 16'h12B9;
	localparam logic [15:0] ASP_OFS_ELS_LAST    = 16'h12BC;

	localparam logic [31:0] ASP_FREQ_MAX        = 32'h0000_9C40;
	localparam logic [31:0] ASP_FREQ_MIN_S      = 32'hFFFF_63C0;
	localparam logic [15:0] ASP_RATIO_MAX       = 16'h0064;
	localparam logic [15:0] ASP_AUX_RATIO_MIN   = 16'hFF9C;
	localparam logic [15:0] ASP_CURVE_MIN       = 16'h0001;
	localparam logic [15:0] ASP_CURVE_MAX       = 16'h000A;
	localparam logic [15:0] ASP_SRC_MAX         = 16'h0007;
	localparam logic [15:0] ASP_OP_MAX          = 16'h0002;
	localparam logic [15:0] ASP_ELS_MAX         = 16'h0032;

	localparam logic [6:0]  ASP_RST_CUR_ER      = 7'h64;
	localparam logic [7:0]  ASP_RST_AUX_SR      = 8'h00;
	localparam logic [7:0]  ASP_RST_AUX_ER      = 8'h64;
	localparam logic [3:0]  ASP_RST_CURVE       = 4'h2;
	localparam logic [5:0]  ASP_RST_ELS         = 6'h19;

	typedef struct packed {
		logic [31:0]        cur_sf;
		logic [31:0]        cur_ef;
		logic [6:0]         cur_sr;
		logic [6:0]         cur_er;
		logic               cur_sel;
		logic signed [31:0] aux_sf;
		logic signed [31:0] aux_ef;
		logic signed [7:0]  aux_sr;
		logic signed [7:0]  aux_er;
		logic [3:0]         acc_curve;
		logic [3:0]         dec_curve;
		logic [2:0]         src_a;
		logic [2:0]         src_b;
		logic [1:0]         op;
		logic [31:0]        add_amt;
		logic               add_sgn;
		logic [3:0][5:0]    els;
		logic [15:0]        hold;
		logic [15:0]        rd_data;
		logic               rd_valid;
		logic               wr_err;
		logic [31:0]        low_freq;
		logic [7:0]         src_a_oh;
		logic [7:0]         src_b_oh;
		logic [2:0]         op_oh;
		logic signed [31:0] add_eff;
	} asp_state_t;
endpackage

// ==== dv/asp_master_model.sv ====
// Register-port master model standing in for the serial link's command layer.
// Assumes the bank takes one strobe per rising clk_in edge and answers one cycle later.
`timescale 1ns/1ps
module asp_master_model (
	input  wire logic        clk_in,
	input  wire logic        rd_valid_in,
	input  wire logic [15:0] rd_data_in,
	input  wire logic        wr_err_in,
	output logic             wr_en_out,
	output logic             rd_en_out,
	output logic [15:0]      addr_out,
	output logic [15:0]      wr_data_out
);
	initial begin
		wr_en_out   = 1'b0;
		rd_en_out   = 1'b0;
		addr_out    = 16'h0000;
		wr_data_out = 16'h0000;
	end

	// Idle lines are inverted so that a stale address or word never passes for a fresh one.
	task automatic release_bus();
		wr_en_out   <= 1'b0;
		rd_en_out   <= 1'b0;
		addr_out    <= ~addr_out;
		wr_data_out <= ~wr_data_out;
	endtask

	task automatic write(input logic [15:0] addr, input logic [15:0] data, output logic err);
		@(posedge clk_in);
		wr_en_out   <= 1'b1;
		addr_out    <= addr;
		wr_data_out <= data;
		@(posedge clk_in);
		release_bus();
		#1;
		err = wr_err_in;
	endtask

	task automatic read(input logic [15:0] addr, output logic [15:0] data, output logic vld);
		@(posedge clk_in);
		rd_en_out <= 1'b1;
		addr_out  <= addr;
		@(posedge clk_in);
		release_bus();
		#1;
		vld  = rd_valid_in;
		data = rd_data_in;
	endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the parameter bank, driven through the master model.
// Assumes the bank's package and module are compiled first.
`timescale 1ns/1ps
module tb;
	import asp_pkg::*;
	logic               clk_in, rst_in, wr_en, rd_en, rd_vld, wr_err;
	logic [15:0]        addr, wdata, rdata;
	logic [31:0]        csf, cef, clow;
	logic [6:0]         csr, cer;
	logic signed [31:0] asf, aef, fadd;
	logic signed [7:0]  asr, aer;
	logic [3:0]         acc, dec;
	logic [7:0]         sa, sb;
	logic [2:0]         op;
	logic [23:0]        els, ex;
	int                 bad_count, comparisons, cycles;

	asp_master_model host (.clk_in(clk_in), .rd_valid_in(rd_vld), .rd_data_in(rdata),
		.wr_err_in(wr_err), .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
		.wr_data_out(wdata));
	asp_param_bank dut (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
		.addr_in(addr), .wr_data_in(wdata), .rd_data_out(rdata), .rd_valid_out(rd_vld),
		.wr_err_out(wr_err), .cur_start_freq_out(csf), .cur_end_freq_out(cef),
		.cur_start_ratio_out(csr), .cur_end_ratio_out(cer), .cur_low_freq_out(clow),
		.aux_start_freq_out(asf), .aux_end_freq_out(aef), .aux_start_ratio_out(asr),
		.aux_end_ratio_out(aer), .accel_curve_out(acc), .decel_curve_out(dec),
		.src_a_onehot_out(sa), .src_b_onehot_out(sb), .op_onehot_out(op),
		.freq_add_signed_out(fadd), .els_ratio_out(els));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	task automatic wrap_up();
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic exp_err);
		logic err;
		host.write(a, d, err);
		check({31'h0, err}, {31'h0, exp_err});
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        v;
		host.read(a, d, v);
		check({31'h0, v}, 32'h0000_0001);
		check({16'h0, d}, {16'h0, exp});
	endtask

	// A hang would otherwise never reach the verdict.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			wrap_up();
		end
	end

	initial begin
		rst_in = 1'b1;
		bad_count = 0;
		comparisons = 0;
		cycles = 0;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		check(cer, 32'h0000_0064);
		check({acc, dec}, 32'h0000_0022);
		check(els, 32'h0065_9659);
		rd(ASP_OFS_AUX_ER, 16'h0064);
		wr(ASP_OFS_ADD_AMT_HI, 16'h0000, 1'b0);
		wr(ASP_OFS_ADD_AMT_LO, 16'h012C, 1'b0);
		check(fadd, 32'h0000_012C);
		wr(ASP_OFS_ADD_SIGN, 16'h0001, 1'b0);
		check(fadd, 32'hFFFF_FED4);
		wr(ASP_OFS_ADD_SIGN, 16'h0002, 1'b1);
		rd(ASP_OFS_ADD_AMT_LO, 16'h012C);
		wr(ASP_OFS_ADD_AMT_LO, 16'h9C40, 1'b0);
		wr(ASP_OFS_ADD_AMT_LO, 16'h9C41, 1'b1);
		check(fadd, 32'hFFFF_63C0);
		wr(ASP_OFS_ADD_AMT_HI, 16'h0001, 1'b0);
		wr(ASP_OFS_ADD_AMT_LO, 16'h0000, 1'b1);
		wr(ASP_OFS_CUR_ER, 16'h0032, 1'b0);
		wr(ASP_OFS_CUR_SR, 16'h0033, 1'b1);
		wr(ASP_OFS_CUR_SR, 16'h0032, 1'b0);
		wr(ASP_OFS_CUR_ER, 16'h0031, 1'b1);
		check({csr, cer}, 32'h0000_1932);
		wr(ASP_OFS_CUR_ER, 16'h0065, 1'b1);
		wr(ASP_OFS_AUX_SR, 16'hFF9B, 1'b1);
		wr(ASP_OFS_AUX_SR, 16'hFF9C, 1'b0);
		wr(ASP_OFS_AUX_ER, 16'h0065, 1'b1);
		check({asr, aer}, 32'h0000_9C64);
		wr(ASP_OFS_AUX_SF_HI, 16'hFFFF, 1'b0);
		wr(ASP_OFS_AUX_SF_LO, 16'h63C0, 1'b0);
		check(asf, 32'hFFFF_63C0);
		rd(ASP_OFS_AUX_SF_HI, 16'hFFFF);
		wr(ASP_OFS_AUX_EF_HI, 16'hFFFF, 1'b0);
		wr(ASP_OFS_AUX_EF_LO, 16'hFF38, 1'b0);
		check(aef, 32'hFFFF_FF38);
		wr(ASP_OFS_AUX_SF_HI, 16'hFFFF, 1'b0);
		wr(ASP_OFS_AUX_SF_LO, 16'h63BF, 1'b1);
		wr(ASP_OFS_CUR_SF_HI, 16'h0000, 1'b0);
		wr(ASP_OFS_CUR_SF_LO, 16'h04D2, 1'b0);
		check(clow, 32'h0000_04D2);
		wr(ASP_OFS_CUR_EF_HI, 16'h0000, 1'b0);
		wr(ASP_OFS_CUR_EF_LO, 16'h9C40, 1'b0);
		check(cef, 32'h0000_9C40);
		wr(ASP_OFS_CUR_SEL, 16'h0001, 1'b0);
		check(clow, 32'h0000_0000);
		wr(ASP_OFS_CUR_SEL, 16'h0002, 1'b1);
		wr(ASP_OFS_CUR_SEL, 16'h0000, 1'b0);
		check(clow, 32'h0000_04D2);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 12; i++) begin
				wr(ASP_OFS_ACC_CURVE + 16'(j), 16'(i), (i == 0 || i > 10));
			end
		end
		check({acc, dec}, 32'h0000_00AA);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 9; i++) begin
				wr(ASP_OFS_SRC_A + 16'(j), 16'(i), i > 7);
				check(j ? sb : sa, 32'h0000_0001 << (i > 7 ? 7 : i));
			end
		end
		for (int i = 0; i < 4; i++) begin
			wr(ASP_OFS_OPERATOR, 16'(i), i > 2);
			check(op, 32'h0000_0001 << (i > 2 ? 2 : i));
		end
		for (int j = 0; j < 4; j++) begin
			wr(ASP_OFS_ELS_FIRST + 16'(j), 16'h0033, 1'b1);
			wr(ASP_OFS_ELS_FIRST + 16'(j), 16'(50 - 16 * j), 1'b0);
			ex[6 * j +: 6] = 6'(50 - 16 * j);
		end
		check(els, ex);
		wr(16'h1288, 16'h1234, 1'b0);
		rd(16'h1288, 16'h0000);
		wr(16'h12B2, 16'h5A5A, 1'b0);
		rd(16'h12B2, 16'h0000);
		rd(16'h12BD, 16'h0000);
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		check(cer, 32'h0000_0064);
		check(fadd, 32'h0000_0000);
		rd(ASP_OFS_ELS_FIRST, 16'h0019);
		wrap_up();
	end
endmodule
